/* rtl/phb_pkg.sv */
package phb_pkg;

	// ****************************************
	// Command codes and address window
	// ****************************************
	localparam logic [3:0]  CMD_MEM_RD = 4'h6;
	localparam logic [3:0]  CMD_MEM_WR = 4'h7;
	localparam logic [3:0]  BE_ALL_N   = 4'h0;
	localparam logic [31:0] MEM_TOP    = 32'h4000_0000; // Claimed window is [0, top)
	localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [4:0]  GNT_NONE   = 5'h00;
	localparam logic [4:0]  LAST_RST   = 5'h10; // First pick after reset is slot 0
	localparam logic [3:0]  LEN_ONE    = 4'h1;
	localparam logic [2:0]  ABORT_CYC  = 3'h4;  // No claim by fifth clock means abort
	localparam int          NUM_REQ    = 5;

	// Even parity across address/data and command lines
	function automatic logic phb_par(input logic [31:0] ad, input logic [3:0] cbe);
		return ^{ad, cbe};
	endfunction

	// Round robin: nearest requester after the last one granted
	function automatic logic [4:0] phb_rr(input logic [4:0] req, input logic [4:0] last);
		int         idx;
		logic [4:0] pick;
		idx  = 0;
		pick = GNT_NONE;
		for (int i = 0; i < NUM_REQ; i++) begin
			if (last[i]) idx = i;
		end
		for (int k = NUM_REQ; k >= 1; k--) begin
			if (req[(idx + k) % NUM_REQ]) pick = 5'(5'h01 << ((idx + k) % NUM_REQ));
		end
		return pick;
	endfunction

endpackage

/* rtl/phb_pci_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface phb_pci_if;

	// ****************************************
	// Resolved bus lines
	// ****************************************
	logic [31:0] ad;
	logic [3:0]  cbe_n;
	logic        par;
	logic        frame_n;
	logic        irdy_n;
	logic        trdy_n;
	logic        devsel_n;
	logic        stop_n;
	logic        bus_lock_n;
	logic        serr_n;
	logic        clkrun_n;
	logic [4:0]  req_n;
	logic [4:0]  gnt_n;
	logic        bridge_hold_req_n;
	logic        bridge_hold_ack_n;
	logic        ext_cr_oe; // Central clock resource pull, driven from outside

	// ****************************************
	// Drivers of each end
	// ****************************************
	logic [31:0] d_ad;
	logic        d_ad_oe;
	logic        d_par;
	logic        d_par_oe;
	logic        d_trdy_n;
	logic        d_devsel_n;
	logic        d_stop_n;
	logic        d_tgt_oe;
	logic        d_serr_oe;
	logic        d_cr_oe;
	logic [4:0]  d_gnt_n;
	logic        d_hack_n;
	logic        d_arb_oe;
	logic [31:0] i_ad;
	logic        i_ad_oe;
	logic [3:0]  i_cbe_n;
	logic        i_cbe_oe;
	logic        i_par;
	logic        i_par_oe;
	logic        i_frame_n;
	logic        i_irdy_n;
	logic        i_lock_n;
	logic        i_mst_oe;
	logic [4:0]  i_req_n;
	logic        i_hreq_n;

	// Undriven lines float high through the pull-ups
	assign ad       = d_ad_oe ? d_ad : (i_ad_oe ? i_ad : 32'hFFFF_FFFF);
	assign cbe_n    = i_cbe_oe ? i_cbe_n : 4'hF;
	assign par      = d_par_oe ? d_par : (i_par_oe ? i_par : 1'h1);
	assign frame_n  = i_mst_oe ? i_frame_n : 1'h1;
	assign irdy_n   = i_mst_oe ? i_irdy_n : 1'h1;
	assign bus_lock_n = i_mst_oe ? i_lock_n : 1'h1;
	assign trdy_n   = d_tgt_oe ? d_trdy_n : 1'h1;
	assign devsel_n = d_tgt_oe ? d_devsel_n : 1'h1;
	assign stop_n   = d_tgt_oe ? d_stop_n : 1'h1;
	assign serr_n   = !d_serr_oe;
	assign clkrun_n = !(d_cr_oe || ext_cr_oe);
	assign gnt_n    = d_arb_oe ? d_gnt_n : 5'h1F;
	assign bridge_hold_ack_n = d_arb_oe ? d_hack_n : 1'h1;
	assign req_n    = i_req_n;
	assign bridge_hold_req_n = i_hreq_n;

	modport dev_mp (
		input  ad, cbe_n, par, frame_n, irdy_n, bus_lock_n, clkrun_n, req_n,
		input  bridge_hold_req_n,
		output d_ad, d_ad_oe, d_par, d_par_oe, d_trdy_n, d_devsel_n, d_stop_n,
		output d_tgt_oe, d_serr_oe, d_cr_oe, d_gnt_n, d_hack_n, d_arb_oe
	);

	modport ini_mp (
		input  ad, frame_n, irdy_n, trdy_n, devsel_n, stop_n, gnt_n,
		input  bridge_hold_ack_n, serr_n,
		output i_ad, i_ad_oe, i_cbe_n, i_cbe_oe, i_par, i_par_oe, i_frame_n,
		output i_irdy_n, i_lock_n, i_mst_oe, i_req_n, i_hreq_n
	);

endinterface
`default_nettype wire

/* rtl/phb_buf2.sv */
`timescale 1ns/10ps
`default_nettype none
module phb_buf2
	import phb_pkg::*;
#(
	parameter int W = 68,
	parameter int D = 2  // Power of two, pointers wrap naturally
) (
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;

	wire logic push = in_valid && in_ready;
	wire logic pop  = out_valid && out_ready;

	// Honest full and empty straight from the fill count
	assign in_ready  = cnt_q != (AW+1)'(D);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rp_q];

	// Storage, no reset needed on the data words
	always_ff @(posedge clk_sys) begin
		if (push) mem_q[wp_q] <= in_data;
	end

	// Pointers and fill count
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (pop) rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule
`default_nettype wire

/* rtl/phb_target.sv */
`timescale 1ns/10ps
`default_nettype none
module phb_target
	import phb_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	phb_pci_if.dev_mp        pci,
	output logic             mw_valid,
	input  wire logic        mw_ready,
	output logic [31:0]      mw_addr,
	output logic [31:0]      mw_data,
	output logic [3:0]       mw_be_n,
	output logic             mr_req,
	output logic [31:0]      mr_addr,
	input  wire logic        mr_valid,
	input  wire logic [31:0] mr_data,
	input  wire logic        post_empty,
	input  wire logic        host_bus_owned,
	output logic             drain_req,
	input  wire logic        err_in,
	input  wire logic        need_clk
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [2:0] {T_IDLE, T_DECODE, T_DATA, T_TURN, T_WAIT} phb_tst_t;

	phb_tst_t    st_q;
	logic [31:0] addr_q;
	logic        wr_q;
	logic        idle_q;
	logic [31:0] rdata_q;
	logic        rd_have_q;
	logic        rd_pend_q;
	logic        mr_req_q;
	logic        stop_q;
	logic        par_q;
	logic        par_oe_q;
	logic        par_ref_q;
	logic        par_chk_q;
	logic        serr_q;
	logic        ack_q;
	logic [4:0]  gnt_q;
	logic [4:0]  last_q;
	logic        en_q;
	logic        cr_oe_q;
	logic        cr_two_q;
	logic        b_in_ready;

	// ****************************************
	// Decode of the sampled bus
	// ****************************************

	// Address phase only after an idle clock, so data never decodes as address
	wire logic bus_idle = pci.frame_n && pci.irdy_n;
	wire logic addr_ph  = (st_q == T_IDLE) && !pci.frame_n && idle_q;
	wire logic is_mem   = (pci.cbe_n == CMD_MEM_RD) || (pci.cbe_n == CMD_MEM_WR);
	// Lock line is not looked at: PCI locks are not honoured here
	wire logic hit      = is_mem && (pci.ad < MEM_TOP);
	wire logic in_data  = st_q == T_DATA;

	// Ready only when a buffer slot or fetched read word is on hand
	wire logic trdy_act = in_data && !stop_q && (wr_q ? b_in_ready : rd_have_q);
	wire logic xfer     = trdy_act && !pci.irdy_n;
	wire logic last_ph  = pci.frame_n && !pci.irdy_n && (xfer || stop_q);
	wire logic ad_oe    = in_data && !wr_q;

	// Hold handshake terms
	wire logic hreq     = !pci.bridge_hold_req_n;
	wire logic buf_mt   = !mw_valid;
	wire logic ack_ok   = hreq && buf_mt && post_empty && host_bus_owned && (st_q == T_IDLE)
		&& bus_idle && (gnt_q == GNT_NONE);

	// Arbiter choice: park nothing while the bridge wants the bus
	wire logic [4:0] req = ~pci.req_n;
	wire logic [4:0] keep = gnt_q & req;
	wire logic [4:0] gnt_d = (hreq || ack_q) ? GNT_NONE
		: ((|keep) ? gnt_q : phb_rr(req, last_q));

	// Clock is wanted while anything is pending on either side
	wire logic need = (|req) || hreq || (st_q != T_IDLE) || need_clk;

	// ****************************************
	// Target sequence
	// ****************************************

	// Claim goes out one clock after decode, the medium slot
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= T_IDLE;
		end else begin
			case (st_q)
				T_IDLE: begin
					if (addr_ph) st_q <= hit ? T_DECODE : T_WAIT;
				end
				T_DECODE: st_q <= T_DATA;
				T_DATA: begin
					if (last_ph) st_q <= T_TURN;
				end
				T_TURN: st_q <= T_IDLE;
				T_WAIT: begin
					if (bus_idle) st_q <= T_IDLE;
				end
				default: st_q <= T_IDLE;
			endcase
		end
	end

	// Address latch and burst advance
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= '0;
			wr_q   <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			idle_q <= bus_idle;
			if (addr_ph) begin
				addr_q <= pci.ad;
				wr_q   <= pci.cbe_n == CMD_MEM_WR;
			end else if (xfer) begin
				addr_q <= addr_q + ADDR_STEP;
			end
		end
	end

	// ****************************************
	// Read fetch
	// ****************************************

	// One word fetched at a time; waits for posted writes so reads see them
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mr_req_q  <= 1'b0;
			rd_pend_q <= 1'b0;
			rd_have_q <= 1'b0;
			rdata_q   <= '0;
		end else begin
			mr_req_q  <= in_data && !wr_q && !rd_have_q && !rd_pend_q && !mr_req_q
				&& !stop_q && buf_mt;
			rd_pend_q <= (mr_req_q || rd_pend_q) && !mr_valid;
			if ((mr_req_q || rd_pend_q) && mr_valid) begin
				rdata_q   <= mr_data;
				rd_have_q <= 1'b1;
			end else if (xfer || !in_data) begin
				rd_have_q <= 1'b0;
			end
		end
	end

	// Disconnect so a waiting bridge is not starved by a long burst
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stop_q <= 1'b0;
		end else begin
			stop_q <= in_data && !last_ph
				&& (stop_q || (hreq && !rd_pend_q && !mr_req_q));
		end
	end

	// ****************************************
	// Parity and system error
	// ****************************************

	// Parity trails its data by one clock in both directions
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			par_q     <= 1'b0;
			par_oe_q  <= 1'b0;
			par_ref_q <= 1'b0;
			par_chk_q <= 1'b0;
			serr_q    <= 1'b0;
		end else begin
			par_q     <= phb_par(rdata_q, pci.cbe_n);
			par_oe_q  <= ad_oe;
			par_ref_q <= phb_par(pci.ad, pci.cbe_n);
			par_chk_q <= addr_ph || (xfer && wr_q);
			serr_q    <= (par_chk_q && (pci.par != par_ref_q)) || err_in;
		end
	end

	// ****************************************
	// Arbiter, hold and clock run
	// ****************************************

	// Grants only move while the bus is idle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gnt_q  <= GNT_NONE;
			last_q <= LAST_RST;
			ack_q  <= 1'b0;
			en_q   <= 1'b0;
		end else begin
			en_q  <= 1'b1;
			// Dropped request releases at once and may come back later
			ack_q <= hreq && (ack_q || ack_ok);
			if (bus_idle) begin
				gnt_q <= gnt_d;
				if (|gnt_d) last_q <= gnt_d;
			end
		end
	end

	// Two-clock pull when the line is seen released and clock is needed
	// A started pull always runs its full two clocks, even if need drops
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cr_oe_q  <= 1'b0;
			cr_two_q <= 1'b0;
		end else begin
			cr_oe_q  <= en_q && ((need && pci.clkrun_n) || (cr_oe_q && !cr_two_q));
			cr_two_q <= cr_oe_q && !cr_two_q;
		end
	end

	// ****************************************
	// Write buffer toward memory
	// ****************************************

	// Full buffer holds off target ready instead of dropping words
	phb_buf2 #(
		.W (68),
		.D (2)
	) u_wbuf (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (xfer && wr_q),
		.in_ready  (b_in_ready),
		.in_data   ({addr_q, pci.ad, pci.cbe_n}),
		.out_valid (mw_valid),
		.out_ready (mw_ready),
		.out_data  ({mw_addr, mw_data, mw_be_n})
	);

	// ****************************************
	// Outputs
	// ****************************************

	// Every enable is a flop or state term that is low in reset
	assign pci.d_ad       = rdata_q;
	assign pci.d_ad_oe    = ad_oe;
	assign pci.d_par      = par_q;
	assign pci.d_par_oe   = par_oe_q;
	assign pci.d_tgt_oe   = in_data || (st_q == T_TURN);
	assign pci.d_devsel_n = !in_data;
	assign pci.d_trdy_n   = !trdy_act;
	assign pci.d_stop_n   = !(stop_q && in_data);
	assign pci.d_serr_oe  = serr_q;
	assign pci.d_cr_oe    = cr_oe_q;
	assign pci.d_gnt_n    = ~gnt_q;
	assign pci.d_hack_n   = !ack_q;
	assign pci.d_arb_oe   = en_q;
	assign mr_req         = mr_req_q;
	assign mr_addr        = addr_q;
	assign drain_req      = hreq && !ack_q;

endmodule
`default_nettype wire

/* rtl/phb_initiator.sv */
`timescale 1ns/10ps
`default_nettype none
module phb_initiator
	import phb_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	phb_pci_if.ini_mp        pci,
	input  wire logic        start,
	input  wire logic        write,
	input  wire logic [31:0] addr,
	input  wire logic [3:0]  len,
	input  wire logic        lock_req,
	input  wire logic [31:0] wdata,
	output logic             wnext,
	output logic [31:0]      rdata,
	output logic             rvalid,
	output logic             done,
	output logic             aborted,
	output logic             busy,
	input  wire logic [3:0]  aux_req,
	output logic [3:0]       aux_gnt,
	input  wire logic        hold_req,
	output logic             hold_ok
);

	typedef enum logic [2:0] {I_IDLE, I_REQ, I_ADDR, I_DATA, I_FIN} phb_ist_t;

	phb_ist_t    st_q;
	logic [31:0] addr_q;
	logic        wr_q;
	logic        lock_q;
	logic [3:0]  left_q;
	logic [31:0] wd_q;
	logic        stopr_q;
	logic [2:0]  wait_q;
	logic        wnext_q;
	logic [31:0] rdata_q;
	logic        rvalid_q;
	logic        done_q;
	logic        abort_q;
	logic        par_q;
	logic        par_oe_q;

	// ****************************************
	// Bus terms
	// ****************************************
	wire logic bus_idle = pci.frame_n && pci.irdy_n;
	wire logic in_addr  = st_q == I_ADDR;
	wire logic in_data  = st_q == I_DATA;
	// Frame drops on the final phase or once stop is seen
	wire logic frame_n  = !(in_addr || (in_data && (left_q != LEN_ONE) && !stopr_q));
	wire logic xfer     = in_data && !pci.trdy_n;
	wire logic stopped  = in_data && !pci.stop_n;
	wire logic fin      = in_data && frame_n && (xfer || stopped);
	wire logic abort    = in_data && pci.devsel_n && (wait_q == ABORT_CYC);
	wire logic [31:0] ad_out = in_addr ? addr_q : wd_q;
	wire logic [3:0] cbe_out = in_addr ? (wr_q ? CMD_MEM_WR : CMD_MEM_RD) : BE_ALL_N;
	wire logic ad_oe    = in_addr || (in_data && wr_q);

	// ****************************************
	// Master sequence
	// ****************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= I_IDLE;
		end else begin
			case (st_q)
				I_IDLE: begin
					if (start) st_q <= I_REQ;
				end
				I_REQ: begin
					if (!pci.gnt_n[0] && bus_idle) st_q <= I_ADDR;
				end
				I_ADDR: st_q <= I_DATA;
				I_DATA: begin
					if (fin || abort) st_q <= I_FIN;
				end
				I_FIN: st_q <= I_IDLE;
				default: st_q <= I_IDLE;
			endcase
		end
	end

	// Command latch, phase count and claim timeout
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			addr_q  <= '0;
			wr_q    <= 1'b0;
			lock_q  <= 1'b0;
			left_q  <= LEN_ONE;
			stopr_q <= 1'b0;
			wait_q  <= '0;
			abort_q <= 1'b0;
		end else if (st_q == I_IDLE) begin
			if (start) begin
				addr_q  <= addr;
				wr_q    <= write;
				lock_q  <= lock_req;
				left_q  <= (len == 4'h0) ? LEN_ONE : len;
				abort_q <= 1'b0;
			end
			stopr_q <= 1'b0;
			wait_q  <= '0;
		end else if (in_data) begin
			if (xfer) left_q <= left_q - LEN_ONE;
			if (stopped) stopr_q <= 1'b1;
			if (pci.devsel_n) wait_q <= wait_q + 3'h1;
			if (abort) abort_q <= 1'b1;
		end
	end

	// Data words: ready is held only because data is always on hand
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wd_q     <= '0;
			wnext_q  <= 1'b0;
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
			done_q   <= 1'b0;
			par_q    <= 1'b0;
			par_oe_q <= 1'b0;
		end else begin
			wnext_q  <= wr_q && (in_addr || (xfer && !fin));
			if (wr_q && (in_addr || (xfer && !fin))) wd_q <= wdata;
			rvalid_q <= xfer && !wr_q;
			if (xfer && !wr_q) rdata_q <= pci.ad;
			done_q   <= st_q == I_FIN;
			par_q    <= phb_par(ad_out, cbe_out);
			par_oe_q <= ad_oe;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign pci.i_ad      = ad_out;
	assign pci.i_ad_oe   = ad_oe;
	assign pci.i_cbe_n   = cbe_out;
	assign pci.i_cbe_oe  = in_addr || in_data;
	assign pci.i_par     = par_q;
	assign pci.i_par_oe  = par_oe_q;
	assign pci.i_frame_n = frame_n;
	assign pci.i_irdy_n  = !in_data;
	assign pci.i_lock_n  = !(lock_q && (in_addr || in_data));
	assign pci.i_mst_oe  = in_addr || in_data || (st_q == I_FIN);
	assign pci.i_req_n   = {~aux_req, st_q != I_REQ};
	assign pci.i_hreq_n  = !hold_req;
	assign aux_gnt       = ~pci.gnt_n[4:1];
	assign hold_ok       = !pci.bridge_hold_ack_n;
	assign wnext         = wnext_q;
	assign rdata         = rdata_q;
	assign rvalid        = rvalid_q;
	assign done          = done_q;
	assign aborted       = abort_q;
	assign busy          = st_q != I_IDLE;

endmodule
`default_nettype wire

/* verification/phb_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module phb_checker
	import phb_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic [31:0] ad,
	input wire logic [3:0]  cbe_n,
	input wire logic        par,
	input wire logic        frame_n,
	input wire logic        irdy_n,
	input wire logic        trdy_n,
	input wire logic        devsel_n,
	input wire logic        stop_n,
	input wire logic [4:0]  gnt_n,
	input wire logic        bridge_hold_req_n,
	input wire logic        bridge_hold_ack_n,
	input wire logic        d_ad_oe,
	input wire logic        d_cr_oe
);
	// ****
	// Helpers
	// ****
	logic      idle_q;
	wire logic start_ph = !frame_n && idle_q;
	wire logic hit      = cbe_n[3:1] == 3'h3 && ad < MEM_TOP;
	wire logic ad_par   = ^{ad, cbe_n};

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// Only idle-to-frame opens a cycle; back-to-back is not decoded
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			idle_q <= 1'b1;
		end else begin
			idle_q <= frame_n && irdy_n;
		end
	end

	// ****
	// Bus checks
	// ****
	a_devsel_medium: assert property (start_ph && hit |-> devsel_n ##1 devsel_n ##1 !devsel_n)
		else $error("devsel not at medium time");
	a_miss_ignored: assert property (start_ph && !hit |-> devsel_n [*5])
		else $error("cycle outside window claimed");
	a_trdy_claimed: assert property (!trdy_n |-> !devsel_n)
		else $error("ready without select");
	a_stop_no_data: assert property (!stop_n |-> trdy_n && !devsel_n)
		else $error("stop with ready");
	a_grant_single: assert property ($onehot0(~gnt_n))
		else $error("two grants");
	a_ack_no_grant: assert property (!bridge_hold_ack_n |-> gnt_n == 5'h1F)
		else $error("grant during hold");
	a_passive_release: assert property ($rose(bridge_hold_req_n) |=> bridge_hold_ack_n)
		else $error("ack kept after release");
	a_read_parity: assert property (d_ad_oe && !irdy_n && !trdy_n |=> par == $past(ad_par))
		else $error("bad parity");
	a_clkrun_two: assert property ($rose(d_cr_oe) |-> d_cr_oe ##1 d_cr_oe ##1 !d_cr_oe)
		else $error("clock run pull length");
	a_clkrun_reset: assert property ($rose(arst_n) |-> !d_cr_oe)
		else $error("clock run driven at release");

	// Main scenarios reached
	c_claim: cover property (start_ph && hit);
	c_hold: cover property (!bridge_hold_ack_n);
	c_clkrun: cover property ($rose(d_cr_oe));
	c_stop: cover property (!stop_n);
endmodule
`default_nettype wire

/* verification/pci_host_bridge_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
module pci_host_bridge_port_test;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        mw_ready = 1'b0;
	logic        mr_valid = 1'b0;
	logic [31:0] mr_data = 32'h0;
	logic        post_empty = 1'b1;
	logic        host_bus_owned = 1'b0;
	logic        err_in = 1'b0;
	logic        need_clk = 1'b0;
	logic        start = 1'b0;
	logic        write = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [3:0]  len = 4'h1;
	logic [3:0]  aux_req = 4'h0;
	logic        hold_req = 1'b0;
	logic        lock_req = 1'b0;
	logic [3:0]  widx = 4'h0;
	logic        rp = 1'b0;
	logic        mw_valid, mr_req, drain_req, wnext, rvalid, done, aborted, busy, hold_ok;
	logic [31:0] mw_addr, mw_data, mr_addr, rdata;
	logic [3:0]  mw_be_n, aux_gnt, w0;
	logic [31:0] mem [64];
	logic [31:0] rq [$];
	int          err_total = 0;
	int          compares = 0;
	int          cyc = 0;
	// Next word shows at once, so back-to-back takes never repeat a word
	wire [31:0]  wdata = {28'hC0DEF00, 4'(widx + {3'h0, wnext})};

	phb_pci_if pci ();
	phb_target u_phb_target (
		.clk_sys, .arst_n, .pci(pci.dev_mp), .mw_valid, .mw_ready, .mw_addr, .mw_data,
		.mw_be_n, .mr_req, .mr_addr, .mr_valid, .mr_data, .post_empty, .host_bus_owned,
		.drain_req, .err_in, .need_clk
	);
	phb_initiator u_phb_initiator (
		.clk_sys, .arst_n, .pci(pci.ini_mp), .start, .write, .addr, .len, .lock_req,
		.wdata, .wnext, .rdata, .rvalid, .done, .aborted, .busy, .aux_req, .aux_gnt,
		.hold_req, .hold_ok
	);
	phb_checker u_phb_checker (
		.clk_sys, .arst_n, .ad(pci.ad), .cbe_n(pci.cbe_n), .par(pci.par),
		.frame_n(pci.frame_n), .irdy_n(pci.irdy_n), .trdy_n(pci.trdy_n),
		.devsel_n(pci.devsel_n), .stop_n(pci.stop_n), .gnt_n(pci.gnt_n),
		.bridge_hold_req_n(pci.bridge_hold_req_n), .bridge_hold_ack_n(pci.bridge_hold_ack_n),
		.d_ad_oe(pci.d_ad_oe), .d_cr_oe(pci.d_cr_oe)
	);

	always #4 clk_sys = ~clk_sys;

	// ****
	// Memory side and watchdog
	// ****
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (mw_valid && mw_ready) mem[mw_addr[7:2]] <= mw_data;
		if (mw_valid && mw_ready) chk(32'(mw_be_n), 32'h0);
		if (wnext) widx <= widx + 4'h1;
		if (rvalid) rq.push_back(rdata);
		if (cyc == 3000) begin
			err_total++;
			test_done();
		end
	end

	// Read answer a cycle late, so the request is surely pending
	always @(negedge clk_sys) begin
		rp <= mr_req;
		mr_valid <= rp;
		mr_data <= mem[mr_addr[7:2]];
	end

	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic run(input logic w, input logic [31:0] a, input logic [3:0] n);
		@(negedge clk_sys);
		start <= 1'b1;
		write <= w;
		addr <= a;
		len <= n;
		@(negedge clk_sys);
		start <= 1'b0;
		repeat (200) if (done !== 1'b1 && aborted !== 1'b1) @(negedge clk_sys);
	endtask

	task automatic test_done();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****
	// Tests
	// ****
	initial begin
		pci.ext_cr_oe = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk(32'(pci.gnt_n), 32'h1F);
		chk(32'({pci.devsel_n, pci.trdy_n, pci.stop_n, pci.bridge_hold_ack_n}), 32'hF);
		arst_n = 1'b1;
		@(negedge clk_sys);
		chk(32'(pci.clkrun_n), 32'h1);
		$display("reset test end");
		w0 = widx;
		fork
			run(1'b1, 32'h40, 4'h4);
			begin
				repeat (25) @(negedge clk_sys);
				chk(32'(mw_valid), 32'h1);
				mw_ready <= 1'b1;
			end
		join
		repeat (4) @(negedge clk_sys);
		for (int k = 0; k < 4; k++) chk(mem[16+k], {28'hC0DEF00, 4'(w0 + k)});
		chk(32'(aborted), 32'h0);
		chk(32'(busy), 32'h0);
		$display("write test end");
		rq.delete();
		// Locked read from a bus master is still served as a plain one
		lock_req <= 1'b1;
		run(1'b0, 32'h40, 4'h4);
		lock_req <= 1'b0;
		chk(32'(rq.size()), 32'h4);
		foreach (rq[k]) chk(rq[k], {28'hC0DEF00, 4'(w0 + k)});
		run(1'b0, 32'h4000_0000, 4'h1);
		chk(32'(aborted), 32'h1);
		$display("read test end");
		// Round robin from slot 0, holder dropped each step
		for (int k = 0; k < 4; k++) begin
			aux_req <= 4'(4'hF << k);
			repeat (20) if (aux_gnt !== 4'(1 << k)) @(negedge clk_sys);
			chk(32'(aux_gnt), 32'(1 << k));
		end
		aux_req <= 4'h0;
		$display("arbiter test end");
		// Hold arrives mid-burst, so the target must cut the read short
		post_empty <= 1'b0;
		rq.delete();
		fork
			run(1'b0, 32'h40, 4'h4);
			begin
				repeat (50) if (rvalid !== 1'b1) @(negedge clk_sys);
				hold_req <= 1'b1;
			end
		join
		chk(32'(rq.size() > 0 && rq.size() < 4), 32'h1);
		repeat (10) @(negedge clk_sys);
		chk({30'h0, hold_ok, drain_req}, 32'h1);
		post_empty <= 1'b1;
		host_bus_owned <= 1'b1;
		repeat (20) if (hold_ok !== 1'b1) @(negedge clk_sys);
		chk({30'h0, hold_ok, drain_req}, 32'h2);
		chk(32'(pci.gnt_n), 32'h1F);
		hold_req <= 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(32'(hold_ok), 32'h0);
		$display("hold test end");
		err_in <= 1'b1;
		@(negedge clk_sys);
		chk(32'(pci.serr_n), 32'h0);
		arst_n = 1'b0;
		#1 chk(32'({pci.serr_n, pci.gnt_n}), 32'h3F);
		err_in <= 1'b0;
		repeat (10) @(negedge clk_sys);
		arst_n = 1'b1;
		$display("error test end");
		@(negedge clk_sys);
		// Line already held low from outside: no pull of our own
		pci.ext_cr_oe <= 1'b1;
		need_clk <= 1'b1;
		repeat (5) @(negedge clk_sys);
		chk(32'(pci.d_cr_oe), 32'h0);
		pci.ext_cr_oe <= 1'b0;
		@(negedge clk_sys);
		repeat (10) if (pci.clkrun_n !== 1'b0) @(negedge clk_sys);
		chk(32'(pci.clkrun_n), 32'h0);
		need_clk <= 1'b0;
		$display("clock run test end");
		repeat (5) @(negedge clk_sys);
		test_done();
	end
endmodule
`default_nettype wire
